// file: src/tws_pkg.sv
package tws_pkg;

   // Phase of a transaction on the serial bus.
   typedef enum logic [2:0] {
      TWS_IDLE,
      TWS_DEVADDR,
      TWS_REGHI,
      TWS_REGLO,
      TWS_WRITE,
      TWS_READ,
      TWS_IGNORE
   } tws_state_e;

   // Request towards the register file of the sensor.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } tws_req_s;

endpackage

// file: src/tws_regs.svh
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// Slave address byte (write form) when the select input is off or low.
`define TWS_DEV_ADDR_DEF 8'h20
// Slave address byte (write form) when the select input is on and high.
`define TWS_DEV_ADDR_ALT 8'h30

// Bit counter value while the eighth data bit is on the wire.
`define TWS_BIT_LAST 4'h7
// Bit counter value during the acknowledge clock period.
`define TWS_BIT_ACK 4'h8
// Bit counter value at the start of a byte.
`define TWS_BIT_FIRST 4'h0
// Bit counter step per serial clock period.
`define TWS_BIT_STEP 4'h1

// Register pointer after reset and its step per byte.
`define TWS_PTR_RST 16'h0000
`define TWS_PTR_STEP 16'h0001

// Position of the direction bit in the address byte; one means read.
`define TWS_DIR_BIT 0
`define TWS_DIR_READ 1'h1

// Reset value of the pin synchronisers and of the read data holder.
`define TWS_SYNC_RST 1'h0
`define TWS_BYTE_RST 8'h00

`endif

// file: src/tws_slave.sv
`timescale 1ns/100ps
`include "tws_regs.svh"

// Operation
// - A high data line in the acknowledge slot is a no-acknowledge.
// - A master no-acknowledge ends a read; the slave then lets go.
// - Address byte bit zero selects the direction: zero write, one read.
// - Acknowledge the address byte only when its address bits match ours.
// - After a write address, two register address bytes, each acked.
// - Register address goes upper byte first, then lower, before data.
// - Every write data byte is acked; stop or restart ends the write.
// - The register pointer steps by one after every byte, read or write.
// - A read with no address phase starts at the current pointer.
// - Sequential reads continue from successive addresses while acked.
// - Sequential writes store bytes at successive addresses until stop.
// - Bytes move most significant bit first; data changes with clock low.
// - The serial clock is input only and is never driven or stretched.
// - Answer 0x20/0x21, or 0x30/0x31 when the select is on and high.
// - Start is data falling with clock high; stop is data rising.
module tws_slave
   import tws_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   input wire logic address_select_en,
   input wire logic address_select_in,
   output tws_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   output logic busy
);

   // Returns one when the address bits of a received byte name this slave.
   function automatic logic addr_match(input logic [7:0] rx,
                                       input logic alt_sel);
      logic [7:0] own;
      own = alt_sel ? `TWS_DEV_ADDR_ALT : `TWS_DEV_ADDR_DEF;
      addr_match = (rx[7:1] == own[7:1]);
   endfunction

   // Serial clock domain: byte capture at the bus.
   logic [7:0] link_shift_q;
   logic [7:0] link_shift_d;

   // System clock domain: pins, edges and transaction state.
   logic [3:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic sel_en_s;
   logic sel_in_s;
   logic scl_p_q;
   logic scl_p_d;
   logic sda_p_q;
   logic sda_p_d;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic active;

   tws_state_e state_q;
   tws_state_e state_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [15:0] ptr_q;
   logic [15:0] ptr_d;
   logic ack_q;
   logic ack_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic rd_cap_q;
   logic rd_cap_d;
   logic oe_q;
   logic oe_d;
   logic out_q;
   logic out_d;
   tws_req_s req_q;
   tws_req_s req_d;
   logic busy_q;
   logic busy_d;

   // Data is stable while the serial clock is high, so its rising edge
   // samples the line directly, most significant bit arriving first.
   always_comb
   begin
      link_shift_d = {link_shift_q[6:0], serial_data_in};
   end

   // The serial clock may stand still between frames; this register holds
   // only data and needs no reset, since every byte refills all eight bits.
   always_ff @(posedge serial_clk)
   begin
      link_shift_q <= link_shift_d;
   end

   // All pins pass two flip-flops; the serial clock is also watched as a
   // level so that the system side sees the same edges as the link side.
   tws_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk(sys_clk),
      .srst(srst),
      .din({serial_clk, serial_data_in, address_select_en,
            address_select_in}),
      .dout(pins_s)
   );

   assign scl_s = pins_s[3];
   assign sda_s = pins_s[2];
   assign sel_en_s = pins_s[1];
   assign sel_in_s = pins_s[0];

   // Edge and bus condition detection on the synchronised levels.
   always_comb
   begin
      scl_p_d = scl_s;
      sda_p_d = sda_s;
      scl_rise = scl_s & ~scl_p_q;
      scl_fall = ~scl_s & scl_p_q;
      start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
      stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
      active = (state_q != TWS_IDLE) && (state_q != TWS_IGNORE);
   end

   // Transaction sequencing. The captured byte is read only after the
   // synchronised rising edge is seen, a few system cycles after the link
   // register settled, and it stays still until the next serial clock rise.
   always_comb
   begin
      state_d = state_q;
      bit_d = bit_q;
      ptr_d = ptr_q;
      ack_d = ack_q;
      tx_d = tx_q;
      oe_d = oe_q;
      out_d = 1'b0; // Open drain: only ever pulls low.
      rd_cap_d = 1'b0;
      req_d = req_q;
      req_d.wr = 1'b0;
      req_d.rd = 1'b0;
      // Read data is taken in the cycle in which the request stands.
      if (rd_cap_q)
      begin
         tx_d = reg_rdata;
      end
      if (start_det)
      begin
         // A start or restart reopens the address phase from any state.
         state_d = TWS_DEVADDR;
         bit_d = `TWS_BIT_FIRST;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end
      else if (stop_det)
      begin
         state_d = TWS_IDLE;
         bit_d = `TWS_BIT_FIRST;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end
      else if (scl_rise && active)
      begin
         if (bit_q == `TWS_BIT_ACK)
         begin
            bit_d = `TWS_BIT_FIRST;
            // After the read address byte this slot holds our own
            // acknowledge, which must not start a second fetch.
            if ((state_q == TWS_READ) && !ack_q)
            begin
               if (sda_s)
               begin
                  // High line in the ack slot is a no-acknowledge.
                  state_d = TWS_IGNORE;
               end
               else
               begin
                  // Master wants more: fetch from the stepped pointer.
                  req_d.rd = 1'b1;
                  req_d.addr = ptr_q;
                  rd_cap_d = 1'b1;
               end
            end
         end
         else
         begin
            bit_d = bit_q + `TWS_BIT_STEP;
            if (bit_q == `TWS_BIT_LAST)
            begin
               unique case (state_q)
                  TWS_DEVADDR:
                  begin
                     if (addr_match(link_shift_q, sel_en_s & sel_in_s))
                     begin
                        ack_d = 1'b1;
                        if (link_shift_q[`TWS_DIR_BIT] == `TWS_DIR_READ)
                        begin
                           // Read starts at the current pointer.
                           state_d = TWS_READ;
                           req_d.rd = 1'b1;
                           req_d.addr = ptr_q;
                           rd_cap_d = 1'b1;
                        end
                        else
                        begin
                           state_d = TWS_REGHI;
                        end
                     end
                     else
                     begin
                        ack_d = 1'b0;
                        state_d = TWS_IGNORE;
                     end
                  end
                  TWS_REGHI:
                  begin
                     ptr_d = {link_shift_q, ptr_q[7:0]};
                     ack_d = 1'b1;
                     state_d = TWS_REGLO;
                  end
                  TWS_REGLO:
                  begin
                     ptr_d = {ptr_q[15:8], link_shift_q};
                     ack_d = 1'b1;
                     state_d = TWS_WRITE;
                  end
                  TWS_WRITE:
                  begin
                     req_d.wr = 1'b1;
                     req_d.addr = ptr_q;
                     req_d.wdata = link_shift_q;
                     ptr_d = ptr_q + `TWS_PTR_STEP;
                     ack_d = 1'b1;
                  end
                  TWS_READ:
                  begin
                     // The master answers this byte; release the line.
                     ptr_d = ptr_q + `TWS_PTR_STEP;
                     ack_d = 1'b0;
                  end
                  default:
                  begin
                     ack_d = 1'b0;
                  end
               endcase
            end
         end
      end
      else if (scl_fall && active)
      begin
         // The line only changes after the clock has gone low.
         if (bit_q == `TWS_BIT_ACK)
         begin
            oe_d = ack_q;
         end
         else if (state_q == TWS_READ)
         begin
            oe_d = ~tx_q[~bit_q[2:0]];
         end
         else
         begin
            oe_d = 1'b0;
         end
      end
      else if (!active)
      begin
         oe_d = 1'b0;
      end
      busy_d = (state_d != TWS_IDLE) && (state_d != TWS_IGNORE);
   end

   // Registers of the system clock domain.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         scl_p_q <= `TWS_SYNC_RST;
         sda_p_q <= `TWS_SYNC_RST;
         state_q <= TWS_IDLE;
         bit_q <= `TWS_BIT_FIRST;
         ptr_q <= `TWS_PTR_RST;
         ack_q <= 1'b0;
         tx_q <= `TWS_BYTE_RST;
         rd_cap_q <= 1'b0;
         oe_q <= 1'b0;
         out_q <= 1'b0;
         req_q <= '0;
         busy_q <= 1'b0;
      end
      else
      begin
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         state_q <= state_d;
         bit_q <= bit_d;
         ptr_q <= ptr_d;
         ack_q <= ack_d;
         tx_q <= tx_d;
         rd_cap_q <= rd_cap_d;
         oe_q <= oe_d;
         out_q <= out_d;
         req_q <= req_d;
         busy_q <= busy_d;
      end
   end

   assign serial_data_out = out_q;
   assign serial_data_oe = oe_q;
   assign reg_req = req_q;
   assign busy = busy_q;

endmodule

// file: src/tws_sync.sv
`timescale 1ns/100ps
`include "tws_regs.svh"

// Two flip-flop synchroniser for a group of independent levels.
module tws_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // The first stage feeds only the second stage.
   always_comb
   begin
      meta_d = din;
      sync_d = meta_q;
   end

   // Both stages clear together on reset.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_q <= {WIDTH{`TWS_SYNC_RST}};
         sync_q <= {WIDTH{`TWS_SYNC_RST}};
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;

endmodule

// file: tb/tws_master_model.sv
`timescale 1ns/100ps
// Behavioural bus master; its clock stands high between frames.
module tws_master_model
(
   output logic scl,
   output logic pull_low,
   input wire logic sda
);
   // Idle bus: clock high, data released.
   initial
   begin
      scl = 1'b1;
      pull_low = 1'b0;
   end
   // One bit; data moves only while the clock is low.
   task automatic bit_io(input logic b, output logic s);
      #8 pull_low = !b;
      #24 scl = 1'b1;
      #16 s = sda;
      #16 scl = 1'b0;
   endtask
   // Start or restart: data falls with clock high.
   task automatic start();
      #8 pull_low = 1'b0;
      #24 scl = 1'b1;
      #32 pull_low = 1'b1;
      #32 scl = 1'b0;
   endtask
   // Stop: data rises with clock high, then the bus rests.
   task automatic stop();
      #8 pull_low = 1'b1;
      #24 scl = 1'b1;
      #32 pull_low = 1'b0;
      #32;
   endtask
   // Byte out MSB first; a high ack slot reads as a nack.
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   // Byte in; ack asks for more, nack ends the read.
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!ack, s);
   endtask
endmodule

// file: tb/tws_slave_assertions.sv
`timescale 1ns/100ps
// Watches the slave ports for request and wire discipline.
module tws_slave_chk
   import tws_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic serial_clk,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   input wire tws_req_s reg_req,
   input wire logic busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic req;
   logic [15:0] last_q;
   logic seq_q;
   assign req = reg_req.wr || reg_req.rd;
   // A pause in busy ends a run, since a new address phase is not
   // visible at the ports; this keeps the step check conservative.
   always_ff @(posedge sys_clk)
   begin
      if (req)
         last_q <= reg_req.addr;
      seq_q <= !srst && busy && (seq_q || req);
   end
   // A write request is a single pulse.
   sequence wr_once;
      reg_req.wr ##1 !reg_req.wr;
   endsequence
   out_low_a: assert property (serial_data_out == 1'b0)
      else $error("data output not low");
   wr_pulse_a: assert property (reg_req.wr |-> wr_once)
      else $error("write request longer than one cycle");
   rd_pulse_a: assert property (reg_req.rd |=> !reg_req.rd)
      else $error("read request longer than one cycle");
   one_kind_a: assert property (!(reg_req.wr && reg_req.rd))
      else $error("read and write requested together");
   oe_clk_low_a: assert property ($changed(serial_data_oe) |->
      !serial_clk) else $error("data drive changed with clock high");
   req_busy_a: assert property (req |-> busy)
      else $error("request outside an addressed transaction");
   addr_hold_a: assert property (!req |-> $stable(reg_req.addr))
      else $error("request address moved without a request");
   seq_step_a: assert property (req && seq_q |->
      reg_req.addr == last_q + 16'h0001) else $error("address not stepped");
endmodule

// file: tb/tws_slave_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         n_mismatch++; \
         $display("MISMATCH %s exp %h got %h", n, e, g); \
      end \
   end
module tws_slave_tb_top
   import tws_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic sel_en = 1'b0;
   logic sel_in = 1'b0;
   logic [7:0] reg_rdata;
   tws_req_s reg_req;
   logic oe, dout, busy, scl, m_low, sda, ack;
   logic [7:0] d;
   logic [7:0] mem [256];
   logic [15:0] wr_addr;
   int n_wr = 0;
   int n_mismatch = 0;
   int n_compared = 0;
   always #2 sys_clk = !sys_clk;
   // Pulled-up wire: low if either side pulls.
   assign sda = !(m_low || (oe && !dout));
   tws_slave DUT (.sys_clk(sys_clk), .srst(srst), .serial_clk(scl),
      .serial_data_in(sda), .serial_data_out(dout), .serial_data_oe(oe),
      .address_select_en(sel_en), .address_select_in(sel_in),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .busy(busy));
   tws_master_model M (.scl(scl), .pull_low(m_low), .sda(sda));
   // Register file stand-in; read data follows the address at once, since
   // the slave takes it while the read request stands.
   assign reg_rdata = mem[reg_req.addr[7:0]];
   always @(posedge sys_clk)
   begin
      if (reg_req.wr)
      begin
         mem[reg_req.addr[7:0]] <= #1 reg_req.wdata;
         wr_addr <= #1 reg_req.addr;
         n_wr <= #1 n_wr + 1;
      end
   end
   task automatic test_done();
      if (n_mismatch == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Select settings 00 and 11 against matching and foreign addresses; 10 only against the foreign 0x30.
   task automatic t_addr();
      logic [10:0] tab [6] = '{{2'b00, 8'h20, 1'b1}, {2'b00, 8'h30, 1'b0},
         {2'b11, 8'h30, 1'b1}, {2'b11, 8'h20, 1'b0},
         {2'b10, 8'h30, 1'b0}, {2'b00, 8'h40, 1'b0}};
      foreach (tab[i])
      begin
         @(posedge sys_clk) #1 {sel_en, sel_in} = tab[i][10:9];
         M.start();
         M.wbyte(tab[i][8:1], ack);
         `CHK("addr_ack", tab[i][0], ack)
         M.wbyte(8'h20, ack);
         `CHK("next_ack", tab[i][0], ack)
         M.stop();
      end
      @(posedge sys_clk) #1 {sel_en, sel_in} = 2'b00;
      `CHK("no_write", 0, n_wr)
   endtask
   // Sequential write of three bytes from 0x1234.
   task automatic t_write();
      logic [7:0] bw [6] = '{8'h20, 8'h12, 8'h34, 8'ha5, 8'h5a, 8'h3c};
      M.start();
      foreach (bw[i])
      begin
         M.wbyte(bw[i], ack);
         `CHK("wr_ack", 1'b1, ack)
      end
      M.stop();
      `CHK("mem34", 8'ha5, mem[8'h34])
      `CHK("mem36", 8'h3c, mem[8'h36])
      `CHK("last_addr", 16'h1236, wr_addr)
   endtask
   // Dummy write to 0x1235, restart, three reads, nack on the last.
   task automatic t_read();
      logic [7:0] ex [3] = '{8'h5a, 8'h3c, 8'hc8};
      M.start();
      M.wbyte(8'h20, ack);
      M.wbyte(8'h12, ack);
      M.wbyte(8'h35, ack);
      M.start();
      M.wbyte(8'h21, ack);
      `CHK("rd_ack", 1'b1, ack)
      foreach (ex[i])
      begin
         M.rbyte(i < 2, d);
         `CHK("rd_data", ex[i], d)
      end
      #24 `CHK("released", 1'b0, oe)
      `CHK("rd_end_busy", 1'b0, busy)
      M.stop();
   endtask
   // Read with no address phase carries on at 0x1238.
   task automatic t_current();
      M.start();
      M.wbyte(8'h21, ack);
      `CHK("cur_ack", 1'b1, ack)
      M.rbyte(1'b1, d);
      `CHK("cur_data0", 8'hc7, d)
      M.rbyte(1'b0, d);
      `CHK("cur_data1", 8'hc6, d)
      M.stop();
   endtask
   // Main sequence: reset, then the scenarios in turn.
   initial
   begin
      foreach (mem[i])
         mem[i] = ~i[7:0];
      repeat (8) @(posedge sys_clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK("busy_rst", 1'b0, busy)
      `CHK("req_rst", 26'h0, reg_req)
      t_addr();
      t_write();
      t_read();
      t_current();
      test_done();
   end
   // Watchdog: the scenarios need well under this span.
   initial
   begin
      #100000;
      n_mismatch++;
      test_done();
   end
endmodule
bind tws_slave tws_slave_chk u_chk (.sys_clk(sys_clk), .srst(srst),
   .serial_clk(serial_clk), .serial_data_out(serial_data_out),
   .serial_data_oe(serial_data_oe), .reg_req(reg_req), .busy(busy));
